// [inc/avb_tx_pkg.sv]
package avb_tx_pkg;

   // stream byte width and buffer depth
   localparam int AVB_DATA_W = 8;
   localparam int FIFO_DEPTH = 16;

   // clock rates in MHz
   localparam int SYS_CLK_MHZ = 125;
   localparam int RATE_1G_MHZ = 125;
   localparam int RATE_100M_MHZ = 25;

   // divider for the slow interface clock, in system cycles
   localparam logic [2:0] DIV_100M = 3'(SYS_CLK_MHZ / RATE_100M_MHZ);
   // system cycles per divided period that the clock stays high
   localparam logic [2:0] DIV_HIGH = 3'h2;
   // values after reset
   localparam logic [2:0] CNT_RESET = 3'h0;
   localparam logic [AVB_DATA_W-1:0] DATA_RESET = 8'h00;

   // one byte of a frame with its side flags
   typedef struct packed {
      logic user;
      logic last;
      logic [AVB_DATA_W-1:0] data;
   } avb_byte_type;

   localparam int BYTE_W = $bits(avb_byte_type);

   // stream acceptance states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_STREAM
   } avb_state_type;

   // which source owns the mac transmit port
   typedef enum logic [1:0] {
      OWN_NONE,
      OWN_AVB,
      OWN_LEG
   } owner_type;

endpackage

// [src/avb_tx_byte_stream.sv]
`timescale 1ns/1ps
module avb_tx_byte_stream #(
   parameter int FIFO_DEPTH = avb_tx_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // line rate select from a pin
   input wire logic i_speed_1g,
   // stream from the framing logic
   output logic o_avb_aclk,
   output logic o_tready,
   input wire logic i_tvalid,
   input wire logic [avb_tx_pkg::AVB_DATA_W-1:0] i_tdata,
   input wire logic i_tlast,
   input wire logic i_tuser,
   // ordinary frames
   input wire logic i_leg_valid,
   input wire logic [avb_tx_pkg::AVB_DATA_W-1:0] i_leg_data,
   input wire logic i_leg_last,
   output logic o_leg_ready,
   // tri_mode_mac transmit port
   output logic o_mac_valid,
   output logic [avb_tx_pkg::AVB_DATA_W-1:0] o_mac_data,
   output logic o_mac_last,
   output logic o_mac_error,
   output logic o_mac_avb,
   input wire logic i_mac_ack
);

   localparam int LW = $clog2(FIFO_DEPTH+1);
   localparam logic [LW-1:0] LVL_FULL = LW'(FIFO_DEPTH);
   localparam logic [LW-1:0] LVL_ALMOST = LW'(FIFO_DEPTH-1);

   // rate select synchroniser
   logic spd_meta_r, spd_1g_r;
   // clock generator
   logic en_r, en_nxt;
   // buffer
   avb_tx_pkg::avb_byte_type fifo_in, fifo_out;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [LW-1:0] fifo_level;
   // stream acceptance
   avb_tx_pkg::avb_state_type state_r, state_nxt;
   logic tready_r, tready_nxt;
   logic take_avb, room_nxt;
   // mac side
   avb_tx_pkg::owner_type owner_r, owner_nxt;
   avb_tx_pkg::avb_byte_type mac_r, mac_nxt;
   logic mac_valid_r, mac_valid_nxt;
   logic mac_avb_r, mac_avb_nxt;
   logic started_r, started_nxt;
   logic last_avb_r, last_avb_nxt;
   logic leg_ready_r, leg_ready_nxt;
   logic take_leg, start_ack, can_load, load_avb, frame_done;

   // the pin is asynchronous, so two flops before any use
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         spd_meta_r <= 1'b0;
         spd_1g_r <= 1'b0;
      end else begin
         spd_meta_r <= i_speed_1g;
         spd_1g_r <= spd_meta_r;
      end
   end

   // interface clock and the byte enable that paces ready
   tx_clk_gen u_clk_gen (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_gig(spd_1g_r),
      .o_aclk(o_avb_aclk),
      .o_en(en_r),
      .o_en_nxt(en_nxt)
   );

   // one byte wide entries, side flags travel beside the data
   always_comb begin
      fifo_in.user = i_tuser;
      fifo_in.last = i_tlast;
      fifo_in.data = i_tdata;
   end

   stream_fifo #(
      .WIDTH(avb_tx_pkg::BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_valid(take_avb),
      .i_data(fifo_in),
      .o_ready(fifo_in_ready),
      .o_valid(fifo_out_valid),
      .o_data(fifo_out),
      .i_ready(fifo_pop),
      .o_level(fifo_level)
   );

   // a byte is taken on a ready cycle; the framing logic cannot stall
   assign take_avb = tready_r & i_tvalid & fifo_in_ready;
   // room for one more after this cycle's write; pops are ignored,
   // which costs a little headroom but never overfills
   assign room_nxt = take_avb ? (fifo_level < LVL_ALMOST)
                              : (fifo_level < LVL_FULL);
   // first byte of a frame leaves the mac port for the first time
   assign start_ack = i_mac_ack & mac_valid_r & mac_avb_r & ~started_r;

   // acceptance: ready only on enable cycles, low while the mac starts
   always_comb begin
      state_nxt = state_r;
      tready_nxt = 1'b0;
      case (state_r)
         avb_tx_pkg::ST_IDLE: begin
            tready_nxt = en_nxt & room_nxt;
            if (take_avb && !i_tlast) begin
               state_nxt = avb_tx_pkg::ST_WAIT;
               tready_nxt = 1'b0;
            end
         end
         avb_tx_pkg::ST_WAIT: begin
            if (start_ack) begin
               state_nxt = avb_tx_pkg::ST_STREAM;
               tready_nxt = en_nxt & room_nxt;
            end
         end
         avb_tx_pkg::ST_STREAM: begin
            tready_nxt = en_nxt & room_nxt;
            if (take_avb && i_tlast) begin
               state_nxt = avb_tx_pkg::ST_IDLE; // ready stays up for back to back
            end
         end
         default: begin
            state_nxt = avb_tx_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r <= avb_tx_pkg::ST_IDLE;
         tready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tready_r <= tready_nxt;
      end
   end

   // the output register may refill as the mac takes its byte,
   // but never past the end of a frame
   assign can_load = ~mac_valid_r | (i_mac_ack & ~mac_r.last);
   assign load_avb = (owner_r == avb_tx_pkg::OWN_AVB) & fifo_out_valid &
                     can_load;
   assign take_leg = leg_ready_r & i_leg_valid;
   assign frame_done = i_mac_ack & mac_valid_r & mac_r.last;
   assign fifo_pop = load_avb;

   // arbitration: stream frames win, but an ordinary frame waiting
   // behind a stream frame gets the next turn so it cannot starve
   always_comb begin
      owner_nxt = owner_r;
      last_avb_nxt = last_avb_r;
      mac_nxt = mac_r;
      mac_valid_nxt = mac_valid_r;
      mac_avb_nxt = mac_avb_r;
      started_nxt = started_r;
      case (owner_r)
         avb_tx_pkg::OWN_NONE: begin
            if (fifo_out_valid && (!i_leg_valid || !last_avb_r)) begin
               owner_nxt = avb_tx_pkg::OWN_AVB;
            end else if (i_leg_valid) begin
               owner_nxt = avb_tx_pkg::OWN_LEG;
            end
         end
         avb_tx_pkg::OWN_AVB, avb_tx_pkg::OWN_LEG: begin
            if (frame_done) begin
               owner_nxt = avb_tx_pkg::OWN_NONE;
               last_avb_nxt = (owner_r == avb_tx_pkg::OWN_AVB);
            end
         end
         default: begin
            owner_nxt = avb_tx_pkg::OWN_NONE;
         end
      endcase
      if (i_mac_ack && mac_valid_r) begin
         mac_valid_nxt = 1'b0;
         if (mac_avb_r) begin
            started_nxt = ~mac_r.last;
         end
      end
      if (load_avb) begin
         mac_nxt = fifo_out; // user flag rides along, no abort
         mac_valid_nxt = 1'b1;
         mac_avb_nxt = 1'b1;
      end else if (take_leg) begin
         mac_nxt.data = i_leg_data;
         mac_nxt.last = i_leg_last;
         mac_nxt.user = 1'b0;
         mac_valid_nxt = 1'b1;
         mac_avb_nxt = 1'b0;
      end
      // ordinary bytes are offered one at a time into an empty register
      leg_ready_nxt = (owner_nxt == avb_tx_pkg::OWN_LEG) & ~mac_valid_nxt &
                      ~frame_done;
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         owner_r <= avb_tx_pkg::OWN_NONE;
         last_avb_r <= 1'b0;
         mac_r <= '0;
         mac_valid_r <= 1'b0;
         mac_avb_r <= 1'b0;
         started_r <= 1'b0;
         leg_ready_r <= 1'b0;
      end else begin
         owner_r <= owner_nxt;
         last_avb_r <= last_avb_nxt;
         mac_r <= mac_nxt;
         mac_valid_r <= mac_valid_nxt;
         mac_avb_r <= mac_avb_nxt;
         started_r <= started_nxt;
         leg_ready_r <= leg_ready_nxt;
      end
   end

   // registered outputs
   assign o_tready = tready_r;
   assign o_leg_ready = leg_ready_r;
   assign o_mac_valid = mac_valid_r;
   assign o_mac_data = mac_r.data;
   assign o_mac_last = mac_r.last;
   assign o_mac_error = mac_r.user;
   assign o_mac_avb = mac_avb_r;

   // checks on the acceptance and mac sides
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);

   a_ready_on_enable: assert property (o_tready |-> en_r)
      else $error("ready high outside an enable cycle");

   a_slow_ready_gap: assert property (
      (!spd_1g_r && $past(!spd_1g_r) && o_tready) |=> !o_tready)
      else $error("ready on back to back cycles at 100M");

   a_idle_ready_up: assert property (
      (spd_1g_r && state_r == avb_tx_pkg::ST_IDLE && fifo_level == '0 &&
       !take_avb) |=> o_tready)
      else $error("idle and empty but ready stayed low");

   a_wait_holds_low: assert property (
      (state_r == avb_tx_pkg::ST_WAIT) |-> !o_tready)
      else $error("ready high before the mac started");

   a_start_resumes: assert property (
      (state_r == avb_tx_pkg::ST_WAIT && start_ack) |=>
      (state_r == avb_tx_pkg::ST_STREAM))
      else $error("stream did not resume after mac start");

   a_first_held: assert property (
      (take_avb && !i_tlast && state_r == avb_tx_pkg::ST_IDLE) |=>
      (state_r == avb_tx_pkg::ST_WAIT && !o_tready))
      else $error("ready rose before the first byte left");

   a_byte_passed: assert property (
      load_avb |=> (o_mac_data == $past(fifo_out.data) && o_mac_avb))
      else $error("mac byte differs from buffered byte");

   a_user_kept: assert property (
      (load_avb && fifo_out.user) |=> o_mac_error)
      else $error("user flag lost on its way to the mac");

   a_one_owner: assert property (
      (o_leg_ready |-> owner_r == avb_tx_pkg::OWN_LEG) and
      (load_avb |-> !take_leg))
      else $error("both sources drive the mac at once");

   a_reset_quiet: assert property ($past(!i_resetn) |-> !o_tready)
      else $error("ready high on the first edge after reset");

   c_avb_frame: cover property (
      o_mac_valid && o_mac_avb && o_mac_last && i_mac_ack);
   c_back_to_back: cover property (
      (take_avb && i_tlast) ##1 (i_tvalid && !o_tready) ##[1:20] take_avb);
   c_leg_frame: cover property (take_leg && i_leg_last);
   c_slow_rate: cover property (!spd_1g_r && take_avb);

endmodule

// [src/stream_fifo.sv]
`timescale 1ns/1ps
module stream_fifo #(
   parameter int WIDTH = avb_tx_pkg::BYTE_W,
   parameter int DEPTH = avb_tx_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // fill side
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // drain side
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready,
   // fill level
   output logic [$clog2(DEPTH+1)-1:0] o_level
);

   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH-1);
   localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [LW-1:0] level_r, level_nxt;
   logic push, pop;

   // honest flags straight from the level
   assign o_ready = (level_r != LVL_FULL);
   assign o_valid = (level_r != '0);
   assign o_data = mem_r[rd_ptr_r];
   assign o_level = level_r;
   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;

   // pointer wrap works for any depth, not only powers of two
   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      level_nxt = level_r;
      if (push) begin
         wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? '0 : AW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
         rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : AW'(rd_ptr_r + 1'b1);
      end
      if (push && !pop) begin
         level_nxt = LW'(level_r + 1'b1);
      end else if (pop && !push) begin
         level_nxt = LW'(level_r - 1'b1);
      end
   end

   // reset empties the buffer, dropping any half frame
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         level_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         level_r <= level_nxt;
      end
   end

   // storage needs no reset, the level guards it
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_data;
      end
   end

endmodule

// [src/tx_clk_gen.sv]
`timescale 1ns/1ps
module tx_clk_gen (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // synchronised rate select
   input wire logic i_gig,
   // derived clock and byte enable
   output logic o_aclk,
   output logic o_en,
   output logic o_en_nxt
);

   logic [2:0] cnt_r, cnt_nxt;
   logic phase_r, phase_nxt;
   logic aclk_r, aclk_nxt;
   logic en_r;
   logic wrap;

   // divide by five for 25 MHz; enable on every other divided cycle
   always_comb begin
      wrap = (cnt_r == 3'(avb_tx_pkg::DIV_100M - 3'h1));
      cnt_nxt = wrap ? avb_tx_pkg::CNT_RESET : 3'(cnt_r + 3'h1);
      phase_nxt = wrap ? ~phase_r : phase_r;
      aclk_nxt = (cnt_nxt < avb_tx_pkg::DIV_HIGH);
      o_en_nxt = i_gig | (wrap & phase_r);
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_r <= avb_tx_pkg::CNT_RESET;
         phase_r <= 1'b0;
         aclk_r <= 1'b0;
         en_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
         aclk_r <= aclk_nxt;
         en_r <= o_en_nxt;
      end
   end

   // at 1 Gb/s the interface clock is the system clock itself
   assign o_aclk = i_gig ? i_clk_sys : aclk_r;
   assign o_en = en_r;

   a_div_period: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      (cnt_r == 3'h0) |-> ##5 (cnt_r == 3'h0))
      else $error("divided clock period is not five cycles");

endmodule

// [tb/avb_src_model.sv]
`timescale 1ns/1ps
// framing logic model: nfr frames of len bytes, byte = {frame, index}
module avb_src_model (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // command from the bench
   input wire logic i_go,
   input wire logic [3:0] i_len,
   input wire logic [1:0] i_nfr,
   input wire logic i_bad,
   // stream
   input wire logic i_tready,
   output logic o_tvalid,
   output logic [avb_tx_pkg::AVB_DATA_W-1:0] o_tdata,
   output logic o_tlast,
   output logic o_tuser
);
   logic [1:0] fr_r;
   logic [3:0] idx_r;

   // bus moves 1 ns after the edge; it never stalls once started
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_tvalid <= #1 1'b0;
         o_tlast <= #1 1'b0;
         o_tuser <= #1 1'b0;
         o_tdata <= #1 8'h5A;
         fr_r <= 2'h0;
         idx_r <= 4'h0;
      end else if (o_tvalid && i_tready) begin
         if (o_tlast && fr_r + 2'h1 == i_nfr) begin
            o_tvalid <= #1 1'b0;
            o_tlast <= #1 1'b0;
            o_tdata <= #1 ~o_tdata;
         end else if (o_tlast) begin
            fr_r <= fr_r + 2'h1;
            idx_r <= 4'h0;
            o_tdata <= #1 {2'h0, fr_r + 2'h1, 4'h0};
            o_tlast <= #1 (i_len == 4'h1);
         end else begin
            idx_r <= idx_r + 4'h1;
            o_tdata <= #1 {2'h0, fr_r, idx_r + 4'h1};
            o_tlast <= #1 (idx_r + 4'h2 == i_len);
         end
      end else if (!o_tvalid && i_go) begin
         fr_r <= 2'h0;
         idx_r <= 4'h0;
         o_tvalid <= #1 1'b1;
         o_tdata <= #1 8'h00;
         o_tlast <= #1 (i_len == 4'h1);
         o_tuser <= #1 i_bad;
      end else if (!o_tvalid) begin
         o_tdata <= #1 ~o_tdata; // released bus must not look stable
      end
   end
endmodule

// [tb/avb_tx_byte_stream_tb_top.sv]
`timescale 1ns/1ps
module avb_tx_byte_stream_tb_top;
   logic i_clk_sys, i_resetn, i_speed_1g, i_tvalid, i_tlast, i_tuser;
   logic i_leg_valid, i_leg_last, i_mac_ack, go, bad, pend, o_avb_aclk;
   logic o_tready, o_leg_ready, o_mac_valid, o_mac_last, o_mac_error;
   logic o_mac_avb;
   logic [7:0] i_tdata, i_leg_data, o_mac_data;
   logic [3:0] len;
   logic [1:0] nfr;
   logic [10:0] mq[$];
   int errors, num_checks, cyc, stall, wcnt, gap, refuse, hi;
   logic [9:0] pat;
   bit seen;

   // small buffer so that a short frame fills it
   avb_tx_byte_stream #(.FIFO_DEPTH(4)) dut (.i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn), .i_speed_1g(i_speed_1g), .o_avb_aclk(o_avb_aclk),
      .o_tready(o_tready), .i_tvalid(i_tvalid), .i_tdata(i_tdata),
      .i_tlast(i_tlast), .i_tuser(i_tuser), .i_leg_valid(i_leg_valid),
      .i_leg_data(i_leg_data), .i_leg_last(i_leg_last),
      .o_leg_ready(o_leg_ready), .o_mac_valid(o_mac_valid),
      .o_mac_data(o_mac_data), .o_mac_last(o_mac_last),
      .o_mac_error(o_mac_error), .o_mac_avb(o_mac_avb),
      .i_mac_ack(i_mac_ack));

   avb_src_model u_src (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_go(go), .i_len(len), .i_nfr(nfr), .i_bad(bad),
      .i_tready(o_tready), .o_tvalid(i_tvalid), .o_tdata(i_tdata),
      .o_tlast(i_tlast), .o_tuser(i_tuser));

   task automatic chk(input string nm, input logic [15:0] seen_v,
                      input logic [15:0] exp);
      num_checks++;
      if (seen_v !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // 125 MHz system clock
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   // mac model acks after stall cycles; monitor watches ready timing
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
      if (pend) chk("ready_low", o_tready, 1'b0);
      if (o_tready) begin
         if (!i_speed_1g && seen) chk("ready_gap", gap >= 9, 1'b1);
         gap = 0;
         seen = 1;
      end else gap++;
      if (i_speed_1g && i_tvalid && !pend && !o_tready) refuse++;
      if (i_mac_ack && o_mac_valid) begin
         mq.push_back({o_mac_avb, o_mac_error, o_mac_last, o_mac_data});
         if (o_mac_avb && o_mac_data[3:0] == 4'h0) pend = 0;
      end
      if (o_tready && i_tvalid && i_tdata[3:0] == 4'h0 && !i_tlast) pend = 1;
      if (!i_resetn) begin
         pend = 0;
         seen = 0;
         wcnt = 0;
         i_mac_ack <= #1 1'b0;
      end else if (i_mac_ack) begin
         i_mac_ack <= #1 1'b0;
         wcnt = 0;
      end else if (o_mac_valid) begin
         if (wcnt >= stall) i_mac_ack <= #1 1'b1;
         else wcnt++;
      end
   end

   // ordinary frame source: A0, A1, A2 with last
   always @(posedge i_clk_sys) begin
      if (i_leg_valid && o_leg_ready) begin
         i_leg_data <= #1 i_leg_data + 8'h01;
         i_leg_last <= #1 (i_leg_data == 8'hA1);
         i_leg_valid <= #1 !i_leg_last;
      end
   end

   task automatic do_reset(input int n);
      int w;
      @(posedge i_clk_sys);
      #1 i_resetn = 1'b0;
      repeat (n) @(posedge i_clk_sys);
      chk("ready_rst", o_tready, 1'b0);
      chk("mac_valid_rst", o_mac_valid, 1'b0);
      chk("leg_ready_rst", o_leg_ready, 1'b0);
      #1 i_resetn = 1'b1;
      @(posedge i_clk_sys);
      #1 chk("ready_first", o_tready, 1'b0);
      for (w = 0; w < 30 && o_tready !== 1'b1; w++) @(negedge i_clk_sys);
      chk("ready_up", o_tready, 1'b1);
   endtask

   // sends frames (and 3 ordinary bytes if leg) and judges the mac side
   task automatic run(input logic [3:0] l, input logic [1:0] f,
                      input logic b, input int st, input logic leg);
      int n, w, si, li, sw;
      logic [10:0] exp;
      n = l * f + (leg ? 3 : 0);
      mq.delete();
      @(posedge i_clk_sys);
      #1 {len, nfr, bad, go} = {l, f, b, 1'b1};
      stall = st;
      if (leg) {i_leg_data, i_leg_last, i_leg_valid} = {8'hA0, 2'b01};
      @(posedge i_clk_sys);
      #1 go = 1'b0;
      for (w = 0; w < 3000 && mq.size() < n; w++) @(posedge i_clk_sys);
      repeat (20) @(posedge i_clk_sys);
      chk("byte_count", 16'(mq.size()), 16'(n));
      si = 0;
      li = 0;
      sw = 0;
      foreach (mq[k]) begin
         if (k > 0 && mq[k][10] !== mq[k-1][10]) sw++;
         if (mq[k][10]) begin
            exp = {1'b1, b, (si % l) == l - 1, 2'h0, 2'(si / l), 4'(si % l)};
            si++;
         end else begin
            exp = {2'b00, li == 2, 8'hA0 + 8'(li)};
            li++;
         end
         chk("mac_byte", mq[k], exp);
      end
      chk("frame_turns", 16'(sw), 16'(leg));
   endtask

   // main sequence
   initial begin
      {i_resetn, i_speed_1g, i_leg_valid, i_leg_last, i_mac_ack} = 5'h00;
      {go, bad, pend, len, nfr, i_leg_data} = 17'h00000;
      repeat (20) @(posedge i_clk_sys);
      do_reset(2);
      // own counters: the monitor rewrites gap and cyc on every edge
      hi = 0;
      pat = '0;
      @(negedge i_clk_sys);
      for (int k = 0; k < 10; k++) begin
         @(negedge i_clk_sys);
         hi += int'(o_avb_aclk);
         pat = {pat[8:0], o_avb_aclk};
      end
      chk("aclk_high", 16'(hi), 16'h0004);
      chk("aclk_period", 16'(pat[4:0]), 16'(pat[9:5]));
      run(4'h5, 2'h1, 1'b1, 0, 1'b0);
      #1 i_speed_1g = 1'b1;
      do_reset(3);
      run(4'h6, 2'h1, 1'b0, 0, 1'b0);
      refuse = 0;
      run(4'hC, 2'h2, 1'b0, 6, 1'b0);
      chk("buffer_refused", refuse > 0, 1'b1);
      run(4'h1, 2'h2, 1'b0, 0, 1'b0);
      run(4'h4, 2'h1, 1'b0, 1, 1'b1);
      #1 {len, nfr, go} = {4'hA, 2'h1, 1'b1};
      stall = 3;
      repeat (6) @(posedge i_clk_sys);
      #1 go = 1'b0;
      do_reset(3);
      run(4'h2, 2'h1, 1'b0, 0, 1'b0);
      end_of_test();
   end
endmodule
